/* File: rtl/pad_state_pkg.sv */
// Constants and pad-bundle types for the pad-state and power-mode sequencer.
// Assumes a single 250 MHz clock and pad cells that resolve enables outside.
package pad_state_pkg;

    // ******************************************************************
    // Bus addresses
    // ******************************************************************
    localparam logic [6:0] BUS_ADDR_SEL_LOW  = 7'h36;
    localparam logic [6:0] BUS_ADDR_SEL_HIGH = 7'h10;
    localparam logic [7:0] BUS_WADDR_SEL_LOW  = 8'h6C;
    localparam logic [7:0] BUS_WADDR_SEL_HIGH = 8'h20;

    // ******************************************************************
    // Pad groups and reset values
    // ******************************************************************
    localparam int NUM_LANES   = 5;
    localparam int NUM_GENERAL = 8;
    localparam logic [NUM_LANES-1:0]   LANE_IDLE_VALUE    = 5'h1F;
    localparam logic [NUM_GENERAL-1:0] GENERAL_OE_RESET   = 8'h00;
    localparam logic [NUM_GENERAL-1:0] GENERAL_OUT_RESET  = 8'h00;
    localparam logic                   AUX_OUT_RESET      = 1'b0;

    // ******************************************************************
    // General pad index order
    // ******************************************************************
    localparam int GEN_IDX_FRAME_EXPOSURE = 5;

    typedef enum {
        MODE_RESET,
        MODE_ACTIVE,
        MODE_SW_STANDBY,
        MODE_HW_STANDBY
    } power_mode_t;

    // Lane pads: p/n pairs, clock lane first then data lanes 0..3
    typedef struct packed {
        logic [NUM_LANES-1:0] p_out;
        logic [NUM_LANES-1:0] n_out;
        logic [NUM_LANES-1:0] oe;
    } lane_pads_t;

    // General pads: 0..4 general, 5 exposure, 6 line, 7 frame-sync
    typedef struct packed {
        logic [NUM_GENERAL-1:0] out;
        logic [NUM_GENERAL-1:0] oe;
    } general_pads_t;

    // Configurable pad settings supplied by the register block
    typedef struct packed {
        logic [NUM_LANES-1:0]   lane_idle_value;
        logic [NUM_GENERAL-1:0] general_oe;
        logic [NUM_GENERAL-1:0] general_out;
        logic                   pwm_value;
        logic                   strobe_value;
    } pad_config_t;

endpackage

/* File: rtl/pad_state_power_modes.sv */
// Pad-state and power-mode sequencer of the sensor's digital pads.
// Assumes all pad inputs are synchronous to mclk and pad cells apply pulls.
`timescale 1ns/1ps
module pad_state_power_modes (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    // Control pins from the host
    input  wire logic                        shutdown_reset_n,
    input  wire logic                        power_down_n,
    input  wire logic                        test_mode_in,
    input  wire logic                        bus_address_select,
    // Core requests and configuration
    input  wire logic                        sw_standby_req,
    input  wire pad_state_pkg::pad_config_t  pad_cfg,
    input  wire logic                        stream_lane_en,
    input  wire logic [pad_state_pkg::NUM_LANES-1:0] stream_lane_p,
    input  wire logic [pad_state_pkg::NUM_LANES-1:0] stream_lane_n,
    input  wire logic                        pwm_stream,
    input  wire logic                        strobe_stream,
    // Control-bus pads
    input  wire logic                        bus_data_in,
    input  wire logic                        bus_data_drive_low,
    input  wire logic                        bus_data_drive_high,
    input  wire logic                        bus_clock_in,
    input  wire logic                        system_clock_in,
    output logic                             bus_data_out,
    output logic                             bus_data_oe,
    output logic                             bus_clock_seen,
    output logic                             system_clock_seen,
    output logic                             bus_data_seen,
    // Video lane pads
    output pad_state_pkg::lane_pads_t        lane_pads,
    // Illumination and strobe
    output logic                             illumination_pwm_out,
    output logic                             strobe_out,
    // General pads
    input  wire logic [pad_state_pkg::NUM_GENERAL-1:0] general_in,
    output pad_state_pkg::general_pads_t     general_pads,
    output logic                             frame_exposure_req,
    // Status
    output logic [7:0]                       bus_address,
    output logic                             test_mode,
    output logic                             in_reset,
    output logic                             hw_standby,
    output logic                             sw_standby
);

    // ******************************************************************
    // Mode decoding
    // ******************************************************************
    pad_state_pkg::power_mode_t mode;
    pad_state_pkg::power_mode_t next_mode;
    logic                       addr_latched;

    wire logic shut_active = ~shutdown_reset_n;
    wire logic pwdn_active = ~power_down_n;

    always_comb begin
        next_mode = mode;
        if (shut_active) begin
            next_mode = pad_state_pkg::MODE_RESET;
        end else begin
            unique case (mode)
                pad_state_pkg::MODE_RESET: begin
                    next_mode = pad_state_pkg::MODE_ACTIVE;
                end
                pad_state_pkg::MODE_ACTIVE,
                pad_state_pkg::MODE_SW_STANDBY: begin
                    if (pwdn_active) begin
                        next_mode = pad_state_pkg::MODE_HW_STANDBY;
                    end else if (sw_standby_req) begin
                        next_mode = pad_state_pkg::MODE_SW_STANDBY;
                    end else begin
                        next_mode = pad_state_pkg::MODE_ACTIVE;
                    end
                end
                pad_state_pkg::MODE_HW_STANDBY: begin
                    if (!pwdn_active) begin
                        next_mode = pad_state_pkg::MODE_ACTIVE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode <= pad_state_pkg::MODE_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    wire logic m_reset  = (mode == pad_state_pkg::MODE_RESET);
    wire logic m_hw     = (mode == pad_state_pkg::MODE_HW_STANDBY);
    wire logic m_sw     = (mode == pad_state_pkg::MODE_SW_STANDBY);
    wire logic m_active = (mode == pad_state_pkg::MODE_ACTIVE);
    wire logic m_stby   = m_hw | m_sw;

    assign in_reset   = m_reset;
    assign hw_standby = m_hw;
    assign sw_standby = m_sw;

    // ******************************************************************
    // Address select and test mode
    // ******************************************************************
    // Latched on the first cycle out of reset so a strap glitch later
    // cannot move the device to another bus address.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            addr_latched <= 1'b0;
            bus_address  <= pad_state_pkg::BUS_WADDR_SEL_LOW;
            test_mode    <= 1'b0;
        end else begin
            test_mode <= test_mode_in & ~m_reset;
            if (m_reset) begin
                addr_latched <= 1'b0;
            end else if (!addr_latched) begin
                addr_latched <= 1'b1;
                bus_address  <= bus_address_select ? pad_state_pkg::BUS_WADDR_SEL_HIGH
                                                   : pad_state_pkg::BUS_WADDR_SEL_LOW;
            end
        end
    end

    // ******************************************************************
    // Control-bus and clock pads
    // ******************************************************************
    wire logic bus_pads_live = m_active | m_sw;
    // Released: the data pad is not driven at all, not even low, while reset or hardware standby
    wire logic data_od_mode  = m_reset | m_hw;
    wire logic next_data_oe  = data_od_mode ? 1'b0
                             : (bus_data_drive_low | bus_data_drive_high);
    wire logic next_data_out = bus_data_drive_high & ~bus_data_drive_low & ~data_od_mode;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bus_data_oe       <= 1'b0;
            bus_data_out      <= 1'b0;
            bus_clock_seen    <= 1'b0;
            system_clock_seen <= 1'b0;
            bus_data_seen     <= 1'b1;
        end else begin
            bus_data_oe       <= next_data_oe;
            bus_data_out      <= next_data_out;
            bus_clock_seen    <= bus_pads_live & bus_clock_in;
            system_clock_seen <= bus_pads_live & system_clock_in;
            bus_data_seen     <= bus_pads_live ? bus_data_in : 1'b1;
        end
    end

    // ******************************************************************
    // Video lanes
    // ******************************************************************
    wire logic [pad_state_pkg::NUM_LANES-1:0] lane_idle =
        m_stby ? pad_cfg.lane_idle_value : pad_state_pkg::LANE_IDLE_VALUE;
    wire logic lane_stream = m_active & stream_lane_en;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lane_pads <= '0;
        end else if (m_reset) begin
            lane_pads <= '0;
        end else begin
            lane_pads.oe    <= '1;
            lane_pads.p_out <= lane_stream ? stream_lane_p : lane_idle;
            lane_pads.n_out <= lane_stream ? stream_lane_n : lane_idle;
        end
    end

    // ******************************************************************
    // Illumination and strobe
    // ******************************************************************
    wire logic next_pwm    = m_reset ? pad_state_pkg::AUX_OUT_RESET
                           : m_active ? (pad_cfg.pwm_value | pwm_stream) : pad_cfg.pwm_value;
    wire logic next_strobe = m_reset ? pad_state_pkg::AUX_OUT_RESET
                           : m_active ? (pad_cfg.strobe_value | strobe_stream) : pad_cfg.strobe_value;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            illumination_pwm_out <= pad_state_pkg::AUX_OUT_RESET;
            strobe_out           <= pad_state_pkg::AUX_OUT_RESET;
        end else begin
            illumination_pwm_out <= next_pwm;
            strobe_out           <= next_strobe;
        end
    end

    // ******************************************************************
    // General, exposure and sync pads
    // ******************************************************************
    // Configuration only takes effect in standby; in reset and while
    // streaming the pads fall back to undriven.
    wire logic [pad_state_pkg::NUM_GENERAL-1:0] next_gen_oe =
        m_stby ? pad_cfg.general_oe : pad_state_pkg::GENERAL_OE_RESET;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            general_pads.oe    <= pad_state_pkg::GENERAL_OE_RESET;
            general_pads.out   <= pad_state_pkg::GENERAL_OUT_RESET;
            frame_exposure_req <= 1'b0;
        end else begin
            general_pads.oe    <= next_gen_oe;
            general_pads.out   <= m_stby ? pad_cfg.general_out : pad_state_pkg::GENERAL_OUT_RESET;
            // Input role only while the exposure pad is not driven
            frame_exposure_req <= ~next_gen_oe[pad_state_pkg::GEN_IDX_FRAME_EXPOSURE]
                                & general_in[pad_state_pkg::GEN_IDX_FRAME_EXPOSURE]
                                & ~m_reset;
        end
    end

    // ******************************************************************
    // Checks
    // ******************************************************************
    a_shutdown_holds_reset: assert property (@(posedge mclk) disable iff (!rst_b)
        !shutdown_reset_n |=> in_reset) else $error("shutdown did not hold reset");
    a_pwdn_hw_standby: assert property (@(posedge mclk) disable iff (!rst_b)
        (shutdown_reset_n && !power_down_n && !in_reset) |=> hw_standby)
        else $error("power-down did not enter hardware standby");
    // Leaving hardware standby passes through streaming first, so the
    // sleep request is only honoured from streaming or sleep
    a_sw_standby_entry: assert property (@(posedge mclk) disable iff (!rst_b)
        ($past(shutdown_reset_n) && power_down_n && shutdown_reset_n && sw_standby_req && !in_reset
        && !hw_standby) |=> sw_standby) else $error("software standby not entered");
    a_hw_blocks_sw: assert property (@(posedge mclk) disable iff (!rst_b)
        (hw_standby && shutdown_reset_n && !power_down_n) |=> (hw_standby && !sw_standby))
        else $error("sleep request taken in hardware standby");
    a_lanes_released: assert property (@(posedge mclk) disable iff (!rst_b)
        in_reset ##1 !in_reset |=> (lane_pads.oe == '1 && (stream_lane_en || hw_standby || sw_standby
        || lane_pads.p_out == '1 || $past(stream_lane_en))))
        else $error("lanes not driven high after release");
    a_lanes_hiz_reset: assert property (@(posedge mclk) disable iff (!rst_b)
        in_reset |=> lane_pads.oe == '0) else $error("lanes driven in reset");
    a_aux_zero_reset: assert property (@(posedge mclk) disable iff (!rst_b)
        in_reset |=> (!illumination_pwm_out && !strobe_out)) else $error("aux outputs not zero");
    a_general_hiz: assert property (@(posedge mclk) disable iff (!rst_b)
        (in_reset || $rose(!in_reset)) |=> general_pads.oe == '0)
        else $error("general pads driven");
    a_bus_open_drain: assert property (@(posedge mclk) disable iff (!rst_b)
        (in_reset || hw_standby) |=> !bus_data_oe || !bus_data_out)
        else $error("bus data driven high in open-drain mode");
    a_clock_ignored: assert property (@(posedge mclk) disable iff (!rst_b)
        (in_reset || hw_standby) |=> (!system_clock_seen && !bus_clock_seen))
        else $error("clock accepted while gated");
    a_address_stable: assert property (@(posedge mclk) disable iff (!rst_b)
        (addr_latched && !in_reset) |=> $stable(bus_address))
        else $error("bus address moved");
    a_address_value: assert property (@(posedge mclk) disable iff (!rst_b)
        (!addr_latched && !in_reset) |=> bus_address == ($past(bus_address_select) ? 8'h20 : 8'h6C))
        else $error("wrong bus address");
    a_test_mode_gate: assert property (@(posedge mclk) disable iff (!rst_b)
        !test_mode_in |=> !test_mode) else $error("test mode without input");

endmodule

/* File: test/host_ctrl_model.sv */
// Host controller model: drives the sensor's reset, power and strap pins.
// Assumes the bench changes commands just after a rising mclk edge.
`timescale 1ns/1ps
module host_ctrl_model (
    // Pin commands: bit 1 releases the pin, bit 0 is the driven level
    input  wire logic [1:0] shutdown_cmd,
    input  wire logic [1:0] power_cmd,
    input  wire logic [1:0] test_cmd,
    input  wire logic       addr_sel_cmd,
    // Resolved pin levels
    output logic            shutdown_reset_n,
    output logic            power_down_n,
    output logic            test_mode_in,
    output logic            bus_address_select
);
    // ******************************************************************
    // Pin resolution
    // ******************************************************************
    // A released pin settles at its pull level, never at a stale value
    assign shutdown_reset_n   = shutdown_cmd[1] ? 1'b0 : shutdown_cmd[0];
    assign power_down_n       = power_cmd[1] ? 1'b1 : power_cmd[0];
    assign test_mode_in       = test_cmd[1] ? 1'b0 : test_cmd[0];
    assign bus_address_select = addr_sel_cmd;
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the pad-state and power-mode sequencer.
// Assumes the host model resolves pulls; outputs settle two edges after inputs.
`timescale 1ns/1ps
module testbench;
    localparam logic [1:0] LO = 2'h0;
    localparam logic [1:0] HI = 2'h1;
    localparam logic [1:0] FL = 2'h2;
    logic                                      mclk = 1'b0;
    logic                                      rst_b = 1'b0;
    logic [1:0]                                shutdown_cmd = LO;
    logic [1:0]                                power_cmd = HI;
    logic [1:0]                                test_cmd = LO;
    logic                                      addr_sel_cmd = 1'b0;
    wire logic                                 shutdown_reset_n, power_down_n, test_mode_in, bus_address_select;
    logic                                      sw_standby_req = 1'b0;
    pad_state_pkg::pad_config_t                pad_cfg = '0;
    logic                                      stream_lane_en = 1'b0;
    logic [pad_state_pkg::NUM_LANES-1:0]       stream_lane_p = 5'h00;
    logic [pad_state_pkg::NUM_LANES-1:0]       stream_lane_n = 5'h00;
    logic                                      pwm_stream = 1'b0, strobe_stream = 1'b0;
    logic                                      bus_data_in = 1'b1, bus_data_drive_low = 1'b0;
    logic                                      bus_data_drive_high = 1'b0;
    logic                                      bus_clock_in = 1'b1, system_clock_in = 1'b1;
    logic [pad_state_pkg::NUM_GENERAL-1:0]     general_in = 8'h00;
    logic                                      bus_data_out, bus_data_oe, bus_clock_seen, system_clock_seen;
    logic                                      bus_data_seen, illumination_pwm_out, strobe_out, frame_exposure_req;
    logic                                      test_mode, in_reset, hw_standby, sw_standby;
    pad_state_pkg::lane_pads_t                 lane_pads;
    pad_state_pkg::general_pads_t              general_pads;
    logic [7:0]                                bus_address;
    int                                        err_count = 0;
    int                                        cmp_count = 0;

    host_ctrl_model host (.shutdown_cmd, .power_cmd, .test_cmd, .addr_sel_cmd,
        .shutdown_reset_n, .power_down_n, .test_mode_in, .bus_address_select);

    pad_state_power_modes DUT (.mclk, .rst_b, .shutdown_reset_n, .power_down_n, .test_mode_in,
        .bus_address_select, .sw_standby_req, .pad_cfg, .stream_lane_en, .stream_lane_p, .stream_lane_n,
        .pwm_stream, .strobe_stream, .bus_data_in, .bus_data_drive_low, .bus_data_drive_high, .bus_clock_in,
        .system_clock_in, .bus_data_out, .bus_data_oe, .bus_clock_seen, .system_clock_seen, .bus_data_seen,
        .lane_pads, .illumination_pwm_out, .strobe_out, .general_in, .general_pads, .frame_exposure_req,
        .bus_address, .test_mode, .in_reset, .hw_standby, .sw_standby);

    // ******************************************************************
    // Shared helpers
    // ******************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bchk(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask

    // Two edges of latency plus one spare, sampled after the edge lands
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ******************************************************************
    // Scenarios
    // ******************************************************************
    task automatic t_reset_hold(input logic [1:0] how);
        @(posedge mclk);
        shutdown_cmd <= how;
        bus_data_drive_low <= 1'b1;
        settle();
        bchk(in_reset, 1'b1);
        chk({3'h0, lane_pads.oe}, 8'h00);
        chk(general_pads.oe, 8'h00);
        bchk(illumination_pwm_out, 1'b0);
        bchk(strobe_out, 1'b0);
        bchk(bus_data_oe, 1'b0);
        bchk(system_clock_seen, 1'b0);
        bchk(bus_clock_seen, 1'b0);
    endtask

    task automatic t_release(input logic sel, input logic [7:0] addr);
        @(posedge mclk);
        addr_sel_cmd <= sel;
        shutdown_cmd <= HI;
        settle();
        bchk(in_reset, 1'b0);
        chk(bus_address, addr);
        chk({3'h0, lane_pads.oe}, 8'h1F);
        chk({lane_pads.p_out[3:0], lane_pads.n_out[3:0]}, 8'hFF);
        chk(general_pads.oe, 8'h00);
        chk(general_pads.out, 8'h00);
        bchk(illumination_pwm_out, 1'b0);
        bchk(bus_data_oe, 1'b1);
        bchk(bus_data_out, 1'b0);
        bchk(system_clock_seen & bus_clock_seen, 1'b1);
        @(posedge mclk);
        addr_sel_cmd <= ~sel;
        settle();
        chk(bus_address, addr);
    endtask

    task automatic t_stream();
        @(posedge mclk);
        stream_lane_en <= 1'b1;
        stream_lane_p <= 5'h0A;
        stream_lane_n <= 5'h15;
        pwm_stream <= 1'b1;
        strobe_stream <= 1'b1;
        bus_data_drive_low <= 1'b0;
        bus_data_drive_high <= 1'b1;
        bus_data_in <= 1'b0;
        general_in <= 8'h20;
        settle();
        chk({3'h0, lane_pads.p_out}, 8'h0A);
        chk({3'h0, lane_pads.n_out}, 8'h15);
        bchk(illumination_pwm_out, 1'b1);
        bchk(strobe_out, 1'b1);
        bchk(bus_data_oe & bus_data_out, 1'b1);
        bchk(bus_data_seen, 1'b0);
        bchk(frame_exposure_req, 1'b1);
        @(posedge mclk);
        stream_lane_en <= 1'b0;
        pwm_stream <= 1'b0;
        strobe_stream <= 1'b0;
        general_in <= 8'h00;
    endtask

    task automatic t_standby();
        @(posedge mclk);
        pad_cfg <= {5'h15, 8'hA5, 8'h3C, 1'b1, 1'b1};
        settle();
        chk(general_pads.oe, 8'h00);
        @(posedge mclk);
        power_cmd <= LO;
        sw_standby_req <= 1'b1;
        settle();
        bchk(hw_standby, 1'b1);
        bchk(sw_standby, 1'b0);
        bchk(bus_data_oe, 1'b0);
        bchk(bus_data_out, 1'b0);
        bchk(bus_data_seen, 1'b1);
        bchk(system_clock_seen | bus_clock_seen, 1'b0);
        chk(general_pads.oe, 8'hA5);
        chk(general_pads.out, 8'h3C);
        bchk(illumination_pwm_out & strobe_out, 1'b1);
        chk({3'h0, lane_pads.p_out}, 8'h15);
        @(posedge mclk);
        power_cmd <= FL;
        settle();
        bchk(hw_standby, 1'b0);
        bchk(sw_standby, 1'b1);
        bchk(bus_data_oe, 1'b1);
        bchk(bus_data_out, 1'b1);
        bchk(system_clock_seen, 1'b1);
        chk(general_pads.oe, 8'hA5);
        chk(general_pads.out, 8'h3C);
        chk({3'h0, lane_pads.p_out}, 8'h15);
        @(posedge mclk);
        sw_standby_req <= 1'b0;
        pad_cfg <= '0;
        bus_data_in <= 1'b1;
        power_cmd <= HI;
        settle();
        bchk(sw_standby, 1'b0);
    endtask

    task automatic t_test_mode();
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            test_cmd <= 2'(i);
            settle();
            bchk(test_mode, i == 1);
        end
    endtask

    // ******************************************************************
    // Clock, sequence and watchdog
    // ******************************************************************
    initial begin
        forever #2 mclk = ~mclk;
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset_hold(FL);
        t_release(1'b0, 8'h6C);
        t_stream();
        t_standby();
        t_test_mode();
        t_reset_hold(LO);
        t_release(1'b1, 8'h20);
        wrap_up();
    end

    // The sequence needs about 60 cycles
    initial begin
        repeat (1000) @(posedge mclk);
        err_count++;
        wrap_up();
    end
endmodule
